// *** shared/pin_mux_pkg.sv ***
// constants, types and register map for the port pin function selector
// assumes one 20 MHz clock and an active-low power-on reset
//
// Functional notes
// R1: for gpio or timer use, direction 1 drives the pin, 0 makes it input
// R2: direction bits are ignored for pins routed to dma or address-hold
// R3: direction register clears to 0000 only on external power-on reset
// R4: both select registers clear to 0000 only on power-on reset
// R5: direction register is 16-bit read/write, bit n steers pin n
// R6: upper select register steers pins 15..8, lower steers pins 7..0
// R7: pin 15 code 00 gpio, 10 dma ack ch1, 01 and 11 reserved
// R8: pin 14 code 00 gpio, 10 dma ack ch0, 11 address hold
// R9: upper select bits 11..0 read zero, software writes zero
// R10: lower select bits 15, 13, 11, 9 read zero, written zero
// R11: lower bits 14, 12, 10, 8 pick timer 2b, 2a, 1b, 1a for pins 7..4
// R12: pin 3 code 00 gpio, 01 timer 0d, 10 dma accepted ch1
// R13: pin 2 code 00 gpio, 01 timer 0c, 10 dma request ch1 input
// R14: pin 1 code 00 gpio, 01 timer 0b, 10 dma accepted ch0
// R15: pin 0 code 00 gpio, 01 timer 0a, 10 dma request ch0 input
// R16: in single-chip mode dma and address-hold picks fall back to gpio
// R17: a reserved select code leaves the pin as gpio
package pin_mux_pkg;
   localparam int PIN_COUNT = 16;
   localparam int TIMER_PINS = 8;
   localparam int REG_W = 16;
   localparam int ADDR_W = 2;
   localparam logic [ADDR_W-1:0] DIR_OFFSET = 2'h0;
   localparam logic [ADDR_W-1:0] FN_UPPER_OFFSET = 2'h1;
   localparam logic [ADDR_W-1:0] FN_LOWER_OFFSET = 2'h2;
   localparam logic [REG_W-1:0] DIR_RESET = 16'h0000;
   localparam logic [REG_W-1:0] FN_UPPER_RESET = 16'h0000;
   localparam logic [REG_W-1:0] FN_LOWER_RESET = 16'h0000;
   localparam logic [REG_W-1:0] FN_UPPER_MASK = 16'hf000;
   localparam logic [REG_W-1:0] FN_LOWER_MASK = 16'h55ff;
   localparam int PIN15_SEL_POS = 14;
   localparam int PIN14_SEL_POS = 12;
   localparam int PIN4_SEL_POS = 8;
   localparam logic [1:0] CODE_GPIO = 2'h0;
   localparam logic [1:0] CODE_TIMER = 2'h1;
   localparam logic [1:0] CODE_ALT = 2'h2;
   localparam logic [1:0] CODE_ALT2 = 2'h3;

   typedef enum logic [1:0] {
      FN_GPIO,
      FN_TIMER,
      FN_PERIPH_OUT,
      FN_PERIPH_IN
   } pin_fn_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [REG_W-1:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic drive;
      logic enable;
   } pin_drive_t;
endpackage : pin_mux_pkg

// *** core/pin_route_cell.sv ***
// one port pin: picks the drive source and samples the pin level
// assumes pin level is already synchronised and fn is decoded upstream
`timescale 1ns/10ps
`default_nettype none
module pin_route_cell
   import pin_mux_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire pin_fn_t fn_i,
   input wire logic dir_i,
   input wire logic gpio_drive_i,
   input wire logic timer_drive_i,
   input wire logic periph_drive_i,
   input wire logic pin_level_i,
   output pin_drive_t pin_o,
   output logic gpio_level_o,
   output logic timer_level_o,
   output logic periph_level_o
);
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pin_o <= '0;
      end
      else
      begin
         unique case (fn_i)
            FN_GPIO:
            begin
               pin_o.enable <= dir_i; // [R1]
               pin_o.drive <= gpio_drive_i;
            end
            FN_TIMER:
            begin
               pin_o.enable <= dir_i; // [R1]
               pin_o.drive <= timer_drive_i;
            end
            FN_PERIPH_OUT:
            begin
               pin_o.enable <= 1'b1; // [R2]
               pin_o.drive <= periph_drive_i;
            end
            FN_PERIPH_IN:
            begin
               pin_o.enable <= 1'b0; // [R2]
               pin_o.drive <= 1'b0;
            end
         endcase
      end
   end

   // gpio always sees the pin; others only while routed
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         gpio_level_o <= 1'b0;
         timer_level_o <= 1'b0;
         periph_level_o <= 1'b0;
      end
      else
      begin
         gpio_level_o <= pin_level_i;
         timer_level_o <= (fn_i == FN_TIMER) & pin_level_i;
         periph_level_o <= (fn_i == FN_PERIPH_IN) & pin_level_i;
      end
   end
endmodule : pin_route_cell
`default_nettype wire

// *** core/port_e_pin_function_select.sv ***
// port pin function selector: direction and two select registers
// assumes a one-cycle register port and pins from outside the clock
`timescale 1ns/10ps
`default_nettype none
module port_e_pin_function_select
   import pin_mux_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire reg_req_t reg_req_i,
   output logic [REG_W-1:0] rd_data_o,
   input wire logic single_chip_i,
   input wire logic [PIN_COUNT-1:0] pin_i,
   output logic [PIN_COUNT-1:0] pin_o,
   output logic [PIN_COUNT-1:0] pin_oe_o,
   input wire logic [PIN_COUNT-1:0] gpio_out_i,
   output logic [PIN_COUNT-1:0] gpio_in_o,
   input wire logic [TIMER_PINS-1:0] timer_out_i,
   output logic [TIMER_PINS-1:0] timer_in_o,
   input wire logic dma_ack_ch1_out_i,
   input wire logic dma_ack_ch0_out_i,
   input wire logic address_hold_out_i,
   input wire logic dma_accepted_ch1_out_i,
   input wire logic dma_accepted_ch0_out_i,
   output logic dma_request_ch1_in_o,
   output logic dma_request_ch0_in_o
);
   logic [REG_W-1:0] port_e_direction_ff;
   logic [REG_W-1:0] port_e_function_upper_ff;
   logic [REG_W-1:0] port_e_function_lower_ff;
   logic [PIN_COUNT-1:0] pin_meta_ff;
   logic [PIN_COUNT-1:0] pin_sync_ff;
   logic chip_meta_ff;
   logic chip_ff;
   logic [REG_W-1:0] nxt_rd_data;
   logic [PIN_COUNT-1:0] periph_drive;
   logic [PIN_COUNT-1:0] timer_drive;
   logic [PIN_COUNT-1:0] timer_level;
   logic [PIN_COUNT-1:0] periph_level;
   pin_fn_t fn_vec [PIN_COUNT];

   // decode one pin's use from the select registers
   function automatic pin_fn_t pin_fn(
      input int unsigned pin,
      input logic [REG_W-1:0] up,
      input logic [REG_W-1:0] lo,
      input logic chip
   );
      logic [1:0] c;
      pin_fn_t f;
      c = CODE_GPIO;
      f = FN_GPIO; // [R17]
      if (pin == 15)
      begin
         c = up[PIN15_SEL_POS +: 2];
         if (c == CODE_ALT && !chip) // [R7] [R16]
            f = FN_PERIPH_OUT;
      end
      else if (pin == 14)
      begin
         c = up[PIN14_SEL_POS +: 2];
         if ((c == CODE_ALT || c == CODE_ALT2) && !chip) // [R8] [R16]
            f = FN_PERIPH_OUT;
      end
      else if (pin >= 4 && pin <= 7)
      begin
         if (lo[PIN4_SEL_POS + 2 * (pin - 4)]) // [R11]
            f = FN_TIMER;
      end
      else if (pin <= 3)
      begin
         c = lo[2 * pin +: 2];
         if (c == CODE_TIMER) // [R12] [R13] [R14] [R15]
            f = FN_TIMER;
         else if (c == CODE_ALT && !chip) // [R16]
            f = (pin[0]) ? FN_PERIPH_OUT : FN_PERIPH_IN;
      end
      return f;
   endfunction : pin_fn

   // pin and strap levels cross in through two flops each
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         pin_meta_ff <= '0;
         pin_sync_ff <= '0;
         chip_meta_ff <= 1'b0;
         chip_ff <= 1'b0;
      end
      else
      begin
         pin_meta_ff <= pin_i;
         pin_sync_ff <= pin_meta_ff;
         chip_meta_ff <= single_chip_i;
         chip_ff <= chip_meta_ff;
      end
   end

   // only the power-on reset clears; sleep and watchdog never reach here
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         port_e_direction_ff <= DIR_RESET; // [R3]
      else if (reg_req_i.wr && reg_req_i.addr == DIR_OFFSET)
         port_e_direction_ff <= reg_req_i.wdata; // [R5]
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         port_e_function_upper_ff <= FN_UPPER_RESET; // [R4]
         port_e_function_lower_ff <= FN_LOWER_RESET; // [R4]
      end
      else if (reg_req_i.wr)
      begin
         if (reg_req_i.addr == FN_UPPER_OFFSET)
            port_e_function_upper_ff <=
               reg_req_i.wdata & FN_UPPER_MASK; // [R9] [R6]
         if (reg_req_i.addr == FN_LOWER_OFFSET)
            port_e_function_lower_ff <=
               reg_req_i.wdata & FN_LOWER_MASK; // [R10] [R6]
      end
   end

   // unmapped index reads zero
   always_comb
   begin
      nxt_rd_data = '0;
      unique case (reg_req_i.addr)
         DIR_OFFSET: nxt_rd_data = port_e_direction_ff;
         FN_UPPER_OFFSET: nxt_rd_data = port_e_function_upper_ff;
         FN_LOWER_OFFSET: nxt_rd_data = port_e_function_lower_ff;
         default: nxt_rd_data = '0;
      endcase
   end

   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge sys_clk_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         rd_data_o <= '0;
      else if (reg_req_i.rd)
         rd_data_o <= nxt_rd_data;
      else
         rd_data_o <= '0;
   end

   // peripheral sources; pin 14 picks ack or hold by its code
   always_comb
   begin
      periph_drive = '0;
      periph_drive[15] = dma_ack_ch1_out_i; // [R7]
      periph_drive[14] = (port_e_function_upper_ff[PIN14_SEL_POS +: 2]
         == CODE_ALT2) ? address_hold_out_i : dma_ack_ch0_out_i; // [R8]
      periph_drive[3] = dma_accepted_ch1_out_i; // [R12]
      periph_drive[1] = dma_accepted_ch0_out_i; // [R14]
      timer_drive = {8'h00, timer_out_i};
   end

   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++)
      begin : g_pin
         assign fn_vec[i] = pin_fn(i, port_e_function_upper_ff,
            port_e_function_lower_ff, chip_ff);
         pin_route_cell pin_route_cell_inst (
            .sys_clk_i(sys_clk_i),
            .reset_n_i(reset_n_i),
            .fn_i(fn_vec[i]),
            .dir_i(port_e_direction_ff[i]),
            .gpio_drive_i(gpio_out_i[i]),
            .timer_drive_i(timer_drive[i]),
            .periph_drive_i(periph_drive[i]),
            .pin_level_i(pin_sync_ff[i]),
            .pin_o({pin_o[i], pin_oe_o[i]}),
            .gpio_level_o(gpio_in_o[i]),
            .timer_level_o(timer_level[i]),
            .periph_level_o(periph_level[i])
         );
      end
   endgenerate

   // upper pins carry no timer, so their levels stay zero
   assign timer_in_o = timer_level[TIMER_PINS-1:0];
   assign dma_request_ch1_in_o = periph_level[2]; // [R13]
   assign dma_request_ch0_in_o = periph_level[0]; // [R15]

   // checks
   sequence s_dir_write;
      reg_req_i.wr && reg_req_i.addr == DIR_OFFSET;
   endsequence

   property p_dir_store;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      s_dir_write |=> port_e_direction_ff == $past(reg_req_i.wdata);
   endproperty
   a_dir_store: assert property (p_dir_store) // [R5]
      else $error("direction write not stored");

   property p_dir_read;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      reg_req_i.rd && reg_req_i.addr == DIR_OFFSET && !reg_req_i.wr
      |=> rd_data_o == port_e_direction_ff;
   endproperty
   a_dir_read: assert property (p_dir_read) // [R5]
      else $error("direction readback wrong");

   property p_upper_zero;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      reg_req_i.rd && reg_req_i.addr == FN_UPPER_OFFSET
      |=> rd_data_o[11:0] == 12'h000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) // [R9]
      else $error("upper reserved bits not zero");

   property p_lower_zero;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      reg_req_i.rd && reg_req_i.addr == FN_LOWER_OFFSET
      |=> (rd_data_o & ~FN_LOWER_MASK) == 16'h0000;
   endproperty
   a_lower_zero: assert property (p_lower_zero) // [R10]
      else $error("lower reserved bits not zero");

   sequence s_gpio15_out;
      fn_vec[15] == FN_GPIO && port_e_direction_ff[15];
   endsequence

   property p_gpio_dir;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      s_gpio15_out |=> pin_oe_o[15] && pin_o[15] == $past(gpio_out_i[15]);
   endproperty
   a_gpio_dir: assert property (p_gpio_dir) // [R1]
      else $error("gpio output not driven");

   property p_timer_in;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      fn_vec[4] == FN_TIMER && !port_e_direction_ff[4]
      |=> !pin_oe_o[4] ##1 1'b1;
   endproperty
   a_timer_in: assert property (p_timer_in) // [R1]
      else $error("timer input pin driven");

   property p_dreq_ignores_dir;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_e_function_lower_ff[5:4] == CODE_ALT && !chip_ff
      |=> !pin_oe_o[2];
   endproperty
   a_dreq_ignores_dir: assert property (p_dreq_ignores_dir) // [R2]
      else $error("dma request pin driven");

   property p_hold_out;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_e_function_upper_ff[13:12] == CODE_ALT2 && !chip_ff
      |=> pin_oe_o[14] && pin_o[14] == $past(address_hold_out_i);
   endproperty
   a_hold_out: assert property (p_hold_out) // [R8]
      else $error("address hold not routed");

   property p_single_chip;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      chip_ff && port_e_function_upper_ff[15:14] == CODE_ALT
      |=> pin_oe_o[15] == $past(port_e_direction_ff[15]);
   endproperty
   a_single_chip: assert property (p_single_chip) // [R16]
      else $error("single chip pin not gpio");

   property p_reserved_gpio;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_e_function_lower_ff[1:0] == CODE_ALT2
      |=> pin_o[0] == $past(gpio_out_i[0]) && !dma_request_ch0_in_o;
   endproperty
   a_reserved_gpio: assert property (p_reserved_gpio) // [R17]
      else $error("reserved code not gpio");

   property p_timer_0d;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_e_function_lower_ff[7:6] == CODE_TIMER
      && port_e_direction_ff[3]
      |=> pin_oe_o[3] && pin_o[3] == $past(timer_out_i[3]);
   endproperty
   a_timer_0d: assert property (p_timer_0d) // [R12]
      else $error("timer 0d not routed");

   property p_timer_select;
      @(posedge sys_clk_i) disable iff (!reset_n_i)
      port_e_function_lower_ff[PIN4_SEL_POS + 6]
      |=> timer_in_o[7] == $past(pin_sync_ff[7]);
   endproperty
   a_timer_select: assert property (p_timer_select) // [R11]
      else $error("timer 2b level not routed");
endmodule : port_e_pin_function_select
`default_nettype wire

// *** sim/port_e_far_side.sv ***
// far side of the port pins: outside drivers meet the block's drivers
// assumes the bench supplies the outside level of every pin
`timescale 1ns/10ps
`default_nettype none
module port_e_far_side
   import pin_mux_pkg::*;
(
   input wire logic [PIN_COUNT-1:0] pin_drive_i,
   input wire logic [PIN_COUNT-1:0] pin_enable_i,
   input wire logic [PIN_COUNT-1:0] outside_level_i,
   output logic [PIN_COUNT-1:0] pin_level_o
);
   // a released pin shows the outside level, never the last driven one
   always_comb
   begin
      pin_level_o = (pin_drive_i & pin_enable_i)
         | (outside_level_i & ~pin_enable_i);
   end
endmodule : port_e_far_side
`default_nettype wire

// *** sim/port_e_pin_function_select_test.sv ***
// self-checking bench for the port pin function selector
// assumes the far-side pin model and a 20 MHz clock
`timescale 1ns/10ps
`default_nettype none
module port_e_pin_function_select_test
   import pin_mux_pkg::*;
;
   logic sys_clk_i;
   logic reset_n_i;
   reg_req_t req;
   logic [REG_W-1:0] rd_data;
   logic single_chip;
   logic [PIN_COUNT-1:0] level, drv, oe, gpio_out, gpio_in, ext;
   logic [TIMER_PINS-1:0] timer_out, timer_in;
   logic ack1, ack0, hold, acc1, acc0, dma_request_ch1_in, dma_request_ch0_in;
   int failures = 0;
   int comparisons = 0;

   port_e_pin_function_select port_e_pin_function_select_inst (
      .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .reg_req_i(req),
      .rd_data_o(rd_data), .single_chip_i(single_chip), .pin_i(level),
      .pin_o(drv), .pin_oe_o(oe), .gpio_out_i(gpio_out),
      .gpio_in_o(gpio_in), .timer_out_i(timer_out), .timer_in_o(timer_in),
      .dma_ack_ch1_out_i(ack1), .dma_ack_ch0_out_i(ack0),
      .address_hold_out_i(hold), .dma_accepted_ch1_out_i(acc1),
      .dma_accepted_ch0_out_i(acc0), .dma_request_ch1_in_o(dma_request_ch1_in),
      .dma_request_ch0_in_o(dma_request_ch0_in));

   port_e_far_side port_e_far_side_inst (
      .pin_drive_i(drv), .pin_enable_i(oe), .outside_level_i(ext),
      .pin_level_o(level));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
      @(posedge sys_clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk_i);
      req.wr <= 1'b0;
   endtask : reg_write

   task automatic read_check(input logic [1:0] a, input logic [15:0] exp);
      @(posedge sys_clk_i);
      req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk_i);
      req.rd <= 1'b0;
      #1;
      check(rd_data, exp);
   endtask : read_check

   // waits long enough for the pin synchronisers as well
   task automatic cfg(input logic [15:0] d, input logic [15:0] up,
      input logic [15:0] lo);
      reg_write(DIR_OFFSET, d);
      reg_write(FN_UPPER_OFFSET, up);
      reg_write(FN_LOWER_OFFSET, lo);
      repeat (6) @(posedge sys_clk_i);
      #1;
   endtask : cfg

   task automatic reset_values;
      read_check(DIR_OFFSET, 16'h0000);
      read_check(FN_UPPER_OFFSET, 16'h0000);
      read_check(FN_LOWER_OFFSET, 16'h0000);
      check(oe, 16'h0000);
   endtask : reset_values

   // ones into reserved bits and an unmapped index on purpose
   task automatic access_masks;
      cfg(16'hffff, 16'hffff, 16'hffff);
      reg_write(2'h3, 16'hffff);
      read_check(DIR_OFFSET, 16'hffff);
      read_check(FN_UPPER_OFFSET, 16'hf000);
      read_check(FN_LOWER_OFFSET, 16'h55ff);
      read_check(2'h3, 16'h0000);
   endtask : access_masks

   task automatic gpio_direction;
      @(posedge sys_clk_i);
      gpio_out <= 16'h3cc3;
      ext <= 16'h0ff0;
      cfg(16'ha5c3, 16'h0000, 16'h0000);
      check(oe, 16'ha5c3);
      check(drv, 16'h3cc3);
      check(gpio_in, (16'h3cc3 & 16'ha5c3) | (16'h0ff0 & ~16'ha5c3));
   endtask : gpio_direction

   task automatic timer_routing;
      @(posedge sys_clk_i);
      gpio_out <= 16'h00ff;
      timer_out <= 8'ha5;
      ext <= 16'h003c;
      cfg(16'h00ff, 16'h0000, 16'h4455);
      check({8'h00, drv[7:0]}, 16'h00f5);
      cfg(16'h00ff, 16'h0000, 16'h1100);
      check({8'h00, drv[7:0]}, 16'h00af);
      cfg(16'h0000, 16'h0000, 16'h5555);
      check(oe, 16'h0000);
      check({8'h00, timer_in}, 16'h003c);
   endtask : timer_routing

   task automatic dma_routing;
      @(posedge sys_clk_i);
      {ack1, ack0, hold, acc1, acc0} <= 5'b10110;
      ext <= 16'h0005;
      cfg(16'hffff, 16'hb000, 16'h00aa);
      check(oe, 16'hfffa);
      check({12'h000, drv[15:14], drv[3], drv[1]}, 16'h000e);
      check({14'h0000, dma_request_ch1_in, dma_request_ch0_in}, 16'h0003);
      cfg(16'h0000, 16'ha000, 16'h00aa);
      check(oe, 16'hc00a);
      check({15'h0000, drv[14]}, 16'h0000);
   endtask : dma_routing

   task automatic fallback_cases;
      @(posedge sys_clk_i);
      gpio_out <= 16'h5a5a;
      cfg(16'hffff, 16'h5000, 16'h00ff);
      check(oe, 16'hffff);
      check(drv, 16'h5a5a);
      @(posedge sys_clk_i);
      single_chip <= 1'b1;
      cfg(16'h0000, 16'hb000, 16'h00aa);
      check(oe, 16'h0000);
      check({14'h0000, dma_request_ch1_in, dma_request_ch0_in}, 16'h0000);
   endtask : fallback_cases

   // contents survive until a fresh power-on reset
   task automatic power_on_again;
      cfg(16'h1357, 16'h3000, 16'h0011);
      read_check(FN_LOWER_OFFSET, 16'h0011);
      @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      single_chip <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      reset_values;
   endtask : power_on_again

   task automatic tally_and_finish;
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      sys_clk_i = 1'b0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end

   // whole run is under two hundred cycles; this allows 2000
   initial
   begin
      #100000;
      failures++;
      tally_and_finish;
   end

   initial
   begin
      reset_n_i = 1'b0;
      req = '0;
      single_chip = 1'b0;
      gpio_out = '0;
      ext = '0;
      timer_out = '0;
      {ack1, ack0, hold, acc1, acc0} = 5'b00000;
      repeat (3) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      reset_values;
      access_masks;
      gpio_direction;
      timer_routing;
      dma_routing;
      fallback_cases;
      power_on_again;
      tally_and_finish;
   end
endmodule : port_e_pin_function_select_test
`default_nettype wire
